// ==== rtl/icfe_pkg.sv ====
// Constants, types and register map of the input conditioning front end
package icfe_pkg;
  // ----------------------------------------------------------------
  // Sizes
  // ----------------------------------------------------------------
  localparam int NCH = 12;
  localparam int NHC = 16;
  localparam int NFB = 14;
  localparam int CLK_NS = 100;
  localparam longint CLK_PS = 100000;

  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] A_CTRL = 8'h00;
  localparam logic [7:0] A_INVERT = 8'h04;
  localparam logic [7:0] A_STOPLVL = 8'h08;
  localparam logic [7:0] A_FILT0 = 8'h0C;
  localparam logic [7:0] A_FILT1 = 8'h10;
  localparam logic [7:0] A_FILT2 = 8'h14;
  localparam logic [7:0] A_SSI = 8'h18;
  localparam logic [7:0] A_HOSTCMD = 8'h1C;
  localparam logic [7:0] A_SEL0 = 8'h20;
  localparam logic [7:0] A_SEL1 = 8'h24;
  localparam logic [7:0] A_LOGMASK = 8'h28;
  localparam logic [7:0] A_FBMASK = 8'h2C;
  localparam logic [7:0] A_STATUS = 8'h30;

  // ----------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------
  localparam int SSI_RATE_LSB = 16;
  localparam int STAT_OUT_LSB = 16;
  localparam int LOG_HOST_LSB = 12;
  localparam logic [7:0] FLT_DEF = 8'h07;
  localparam logic [2:0] SSI_MODE = 3'h4;
  localparam logic [3:0] GP_TOP = 4'h8;

  // ----------------------------------------------------------------
  // Filter timing: general times in ns, pulse half periods in ps
  // ----------------------------------------------------------------
  localparam int GP_NS [0:8] = '{0, 10000, 50000, 100000, 200000,
                                 400000, 600000, 1000000, 5000000};
  localparam longint PC_PS [0:7] = '{50000000, 5000000, 2500000,
                                     1000000, 500000, 250000, 125000,
                                     62500};
  localparam logic [3:0] MODE_TOP [0:4] = '{4'h5, 4'h6, 4'h5, 4'h6, 4'h7};
  localparam int GP6_CYC = (GP_NS[6] + CLK_NS - 1) / CLK_NS;
  localparam int GP7_CYC = (GP_NS[7] + CLK_NS - 1) / CLK_NS;
  localparam int GP8_CYC = (GP_NS[8] + CLK_NS - 1) / CLK_NS;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic pulse;
    logic [2:0] mode;
    logic [3:0] idx;
  } icfe_flt_s;

  typedef enum logic [2:0] {
    BUS_IDLE = 3'b001,
    BUS_WR = 3'b010,
    BUS_RDW = 3'b100
  } icfe_bus_e;
endpackage

// ==== rtl/icfe_top.sv ====
// Input channels, host command bits and AHB-Lite register slave
// ------------------------------------------------------------------
// ------------------------------------------------------------------
//
// Our own choices: the address map and the AHB-Lite slave port.
module icfe_top #(
  parameter int NCH = icfe_pkg::NCH,
  parameter int GP6_CYC = icfe_pkg::GP6_CYC,
  parameter int GP7_CYC = icfe_pkg::GP7_CYC,
  parameter int GP8_CYC = icfe_pkg::GP8_CYC
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic [NCH-1:0] pin_in,
  input wire logic [icfe_pkg::NFB-1:0] fb_out,
  output logic [NCH-1:0] chan_out,
  output logic [icfe_pkg::NHC-1:0] host_cmd,
  output logic logic_in
);
  // ----------------------------------------------------------------
  // Filter lengths in cycles
  // ----------------------------------------------------------------
  localparam logic [15:0] GP_LEN [0:8] = '{
    16'((icfe_pkg::GP_NS[0] + icfe_pkg::CLK_NS - 1) / icfe_pkg::CLK_NS),
    16'((icfe_pkg::GP_NS[1] + icfe_pkg::CLK_NS - 1) / icfe_pkg::CLK_NS),
    16'((icfe_pkg::GP_NS[2] + icfe_pkg::CLK_NS - 1) / icfe_pkg::CLK_NS),
    16'((icfe_pkg::GP_NS[3] + icfe_pkg::CLK_NS - 1) / icfe_pkg::CLK_NS),
    16'((icfe_pkg::GP_NS[4] + icfe_pkg::CLK_NS - 1) / icfe_pkg::CLK_NS),
    16'((icfe_pkg::GP_NS[5] + icfe_pkg::CLK_NS - 1) / icfe_pkg::CLK_NS),
    16'(GP6_CYC), 16'(GP7_CYC), 16'(GP8_CYC)};

  // Pulse half period, rounded down, never under one cycle
  function automatic logic [15:0] pc_len(input logic [3:0] i);
    longint c;
    c = icfe_pkg::PC_PS[i[2:0]] / icfe_pkg::CLK_PS;
    pc_len = (c < 1) ? 16'h0001 : 16'(c);
  endfunction

  // Decode a filter setting into a stability length
  function automatic logic [15:0] flt_len(input icfe_pkg::icfe_flt_s c);
    logic [3:0] i;
    logic [3:0] top;
    i = c.idx;
    top = (c.mode > 3'h4) ? icfe_pkg::MODE_TOP[4] : icfe_pkg::MODE_TOP[c.mode];
    if (c.pulse) begin
      if (i > top) i = top;
      flt_len = pc_len(i);
    end else begin
      if (i > icfe_pkg::GP_TOP) i = icfe_pkg::GP_TOP;
      flt_len = GP_LEN[i];
    end
  endfunction

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  icfe_pkg::icfe_bus_e bus_q;
  logic [7:0] addr_q;
  logic hready_q, run_q, logic_q, acc, wr_now;
  logic [31:0] hrdata_q;
  logic [NCH-1:0] inv_q, stop_q, link_q, lmask_q;
  icfe_pkg::icfe_flt_s cfg_q [NCH];
  logic [3:0] ssi_rate_q;
  logic [icfe_pkg::NHC-1:0] host_q, hmask_q;
  logic [3:0] sel_q [NCH];
  logic [icfe_pkg::NFB-1:0] fbmask_q;
  logic [NCH-1:0] s1_q, s2_q, s3_q, pin_q, smp, hit, filt_q, out_q;

  assign acc = hsel & htrans[1] & hready;
  assign wr_now = (bus_q == icfe_pkg::BUS_WR);
  // Read decode shared by the direct and the delayed read
  function automatic logic [31:0] rd_word(input logic [7:0] a);
    rd_word = '0;
    case (a)
      icfe_pkg::A_CTRL: rd_word[0] = run_q;
      icfe_pkg::A_INVERT: rd_word[NCH-1:0] = inv_q;
      icfe_pkg::A_STOPLVL: rd_word[NCH-1:0] = stop_q;
      icfe_pkg::A_FILT0: rd_word = {cfg_q[3], cfg_q[2], cfg_q[1], cfg_q[0]};
      icfe_pkg::A_FILT1: rd_word = {cfg_q[7], cfg_q[6], cfg_q[5], cfg_q[4]};
      icfe_pkg::A_FILT2: rd_word = {cfg_q[11], cfg_q[10], cfg_q[9], cfg_q[8]};
      icfe_pkg::A_SSI: begin
        rd_word[NCH-1:0] = link_q;
        rd_word[icfe_pkg::SSI_RATE_LSB +: 4] = ssi_rate_q;
      end
      icfe_pkg::A_HOSTCMD: rd_word[icfe_pkg::NHC-1:0] = host_q;
      icfe_pkg::A_SEL0: rd_word = {sel_q[7], sel_q[6], sel_q[5], sel_q[4],
                                   sel_q[3], sel_q[2], sel_q[1], sel_q[0]};
      icfe_pkg::A_SEL1: rd_word[15:0] = {sel_q[11], sel_q[10], sel_q[9],
                                         sel_q[8]};
      icfe_pkg::A_LOGMASK: rd_word[27:0] = {hmask_q, lmask_q};
      icfe_pkg::A_FBMASK: rd_word[icfe_pkg::NFB-1:0] = fbmask_q;
      icfe_pkg::A_STATUS: begin
        rd_word[NCH-1:0] = pin_q;
        rd_word[icfe_pkg::STAT_OUT_LSB +: NCH] = out_q;
      end
      default: rd_word = '0;
    endcase
  endfunction

  // ----------------------------------------------------------------
  // AHB-Lite slave: zero wait, one wait for read right after write
  // ----------------------------------------------------------------
  // Reading in the write's data phase would return stale data
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      bus_q <= icfe_pkg::BUS_IDLE;
      addr_q <= '0;
      hready_q <= 1'b1;
      hrdata_q <= '0;
    end else begin
      case (bus_q)
        icfe_pkg::BUS_RDW: begin
          hrdata_q <= rd_word(addr_q);
          hready_q <= 1'b1;
          bus_q <= icfe_pkg::BUS_IDLE;
        end
        default: begin
          bus_q <= icfe_pkg::BUS_IDLE;
          if (acc) begin
            addr_q <= {haddr[7:2], 2'b00};
            if (hwrite) begin
              bus_q <= icfe_pkg::BUS_WR;
            end else if (wr_now) begin
              bus_q <= icfe_pkg::BUS_RDW;
              hready_q <= 1'b0;
            end else begin
              hrdata_q <= rd_word({haddr[7:2], 2'b00});
            end
          end
        end
      endcase
    end
  end

  // Plain control and host registers, written in the data phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      {run_q, inv_q, stop_q, ssi_rate_q} <= '0;
      {host_q, lmask_q, hmask_q, fbmask_q} <= '0;
    end else if (wr_now) begin
      case (addr_q)
        icfe_pkg::A_CTRL: run_q <= hwdata[0];
        icfe_pkg::A_INVERT: inv_q <= hwdata[NCH-1:0];
        icfe_pkg::A_STOPLVL: stop_q <= hwdata[NCH-1:0];
        icfe_pkg::A_SSI: ssi_rate_q <= hwdata[icfe_pkg::SSI_RATE_LSB +: 4];
        icfe_pkg::A_HOSTCMD: host_q <= hwdata[icfe_pkg::NHC-1:0];
        icfe_pkg::A_LOGMASK: {hmask_q, lmask_q} <= hwdata[27:0];
        icfe_pkg::A_FBMASK: fbmask_q <= hwdata[icfe_pkg::NFB-1:0];
        default: run_q <= run_q;
      endcase
    end
  end

  // Link mask on its own, so channel configs can see its fall
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      link_q <= '0;
    end else if (wr_now && addr_q == icfe_pkg::A_SSI) begin
      link_q <= hwdata[NCH-1:0];
    end
  end

  // ----------------------------------------------------------------
  // Per channel: pin selection, config, filter, output stage
  // ----------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < NCH; g++) begin : g_ch
      localparam logic [7:0] FA = (g < 4) ? icfe_pkg::A_FILT0 :
                                  (g < 8) ? icfe_pkg::A_FILT1 :
                                  icfe_pkg::A_FILT2;
      localparam logic [7:0] SA = (g < 8) ? icfe_pkg::A_SEL0 :
                                  icfe_pkg::A_SEL1;
      icfe_pkg::icfe_flt_s eff;
      logic [15:0] len, cnt_q;

      // Filter setting; hardware restore wins over a software write
      always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          cfg_q[g] <= icfe_pkg::FLT_DEF;
        end else if (wr_now && addr_q == icfe_pkg::A_SSI &&
                     link_q[g] && !hwdata[g]) begin
          cfg_q[g] <= icfe_pkg::FLT_DEF;
        end else if (wr_now && addr_q == FA) begin
          cfg_q[g] <= hwdata[(g % 4) * 8 +: 8];
        end
      end

      always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          sel_q[g] <= 4'(g);
        end else if (wr_now && addr_q == SA) begin
          sel_q[g] <= hwdata[(g % 8) * 4 +: 4];
        end
      end

      // linked channel follows the encoder rate
      assign eff = link_q[g] ?
                   {1'b1, icfe_pkg::SSI_MODE, ssi_rate_q} :
                   cfg_q[g];
      // length from time or speed table
      assign len = flt_len(eff);
      assign smp[g] = (sel_q[g] < 4'(NCH)) ? pin_q[sel_q[g]] : 1'b0;
      assign hit[g] = (len == 16'h0000) || (cnt_q >= len - 16'h0001);

      // level taken only after stable len cycles
      always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          cnt_q <= '0;
          filt_q[g] <= 1'b0;
        end else if (smp[g] == filt_q[g]) begin
          cnt_q <= '0;
        end else if (hit[g]) begin
          cnt_q <= '0;
          filt_q[g] <= smp[g];
        end else begin
          cnt_q <= cnt_q + 16'h0001;
        end
      end

      // full length exceeds the sixty percent floor
      a_filt_hold: assert property (@(posedge hclk) disable iff (!hresetn)
        (smp[g] != filt_q[g] && !hit[g]) |=> $stable(filt_q[g]))
        else $error("filter output moved before its length");
      a_filt_take: assert property (@(posedge hclk) disable iff (!hresetn)
        (smp[g] != filt_q[g] && hit[g]) |=> filt_q[g] == $past(smp[g]))
        else $error("filter did not take a stable level");
      a_ssi_revert: assert property (@(posedge hclk) disable iff (!hresetn)
        $fell(link_q[g]) |-> cfg_q[g] == icfe_pkg::FLT_DEF)
        else $error("unlinked channel kept its setting");
    end
  endgenerate

  // ----------------------------------------------------------------
  // Pin synchronisers: a change counts once stages two and three agree
  // ----------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      {s1_q, s2_q, s3_q, pin_q} <= '0;
    end else begin
      s1_q <= pin_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
      pin_q <= (s2_q & s3_q) | (pin_q & (s2_q | s3_q));
    end
  end

  // Channel outputs; a stop level Low means a rise at start for live pins
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      out_q <= '0;
    end else if (!run_q) begin
      out_q <= stop_q;
    end else begin
      out_q <= filt_q ^ inv_q;
    end
  end

  // Logic-operation input; host bits arrive late so channels suit sync use
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      logic_q <= 1'b0;
    // OR of sources, host gated by feedback
    end else begin
      logic_q <= |(out_q & lmask_q) | |(fb_out & fbmask_q) |
                 (~|fbmask_q & |(host_q & hmask_q));
    end
  end

  assign hreadyout = hready_q;
  assign hresp = 1'b0;
  assign hrdata = hrdata_q;
  assign chan_out = out_q;
  assign host_cmd = host_q;
  assign logic_in = logic_q;
  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  sequence s_wr_then_rd;
    wr_now && acc && !hwrite;
  endsequence

  a_rd_wait: assert property (@(posedge hclk) disable iff (!hresetn)
    s_wr_then_rd |=> !hreadyout ##1 hreadyout)
    else $error("read after write not stalled one cycle");
  a_stop_level: assert property (@(posedge hclk) disable iff (!hresetn)
    !run_q |=> chan_out == $past(stop_q))
    else $error("stopped channel not at stop level");
  a_run_invert: assert property (@(posedge hclk) disable iff (!hresetn)
    run_q |=> chan_out == $past(filt_q ^ inv_q))
    else $error("running channel not filtered xor invert");
  a_host_mirror: assert property (@(posedge hclk) disable iff (!hresetn)
    (wr_now && addr_q == icfe_pkg::A_HOSTCMD)
      |=> host_cmd == $past(hwdata[icfe_pkg::NHC-1:0]))
    else $error("host bits do not mirror write");
  a_host_gate: assert property (@(posedge hclk) disable iff (!hresetn)
    (|fbmask_q && !(|(out_q & lmask_q)) && !(|(fb_out & fbmask_q)))
      |=> !logic_in)
    else $error("host bit passed despite feedback source");
  a_or_merge: assert property (@(posedge hclk) disable iff (!hresetn)
    |(out_q & lmask_q) |=> logic_in)
    else $error("selected channel not ORed in");
  a_pin_agree: assert property (@(posedge hclk) disable iff (!hresetn)
    (s2_q != s3_q) |=> $stable(pin_q))
    else $error("pin taken before stages agree");
endmodule

// ==== testbench/icfe_field_model.sv ====
// Field device model: switches and pulse sources on the connector lines
module icfe_field_model (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic [11:0] base,
  input wire logic go,
  input wire logic [3:0] ch,
  input wire logic [15:0] width,
  output logic [11:0] pin_in
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [15:0] cnt_q;
  logic [3:0] ch_q;

  // ----------------------------------------------------------------
  // Pulse timer
  // ----------------------------------------------------------------
  // twelve lines, one pulse at a time
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_q <= 16'h0000;
      ch_q <= 4'h0;
    end else if (go) begin
      cnt_q <= width;
      ch_q <= ch;
    end else if (cnt_q != 16'h0000) begin
      cnt_q <= cnt_q - 16'h0001;
    end
  end

  // Steady levels, one line flipped for exactly width cycles
  always_comb begin
    pin_in = base;
    if (cnt_q != 16'h0000) begin
      pin_in[ch_q] = ~base[ch_q];
    end
  end
endmodule

// ==== testbench/icfe_top_test.sv ====
// Self-checking bench for the input conditioning front end
module icfe_top_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic hclk, hresetn, hsel, hwrite, go, hreadyout, hresp, logic_in;
  logic [31:0] haddr, hwdata, hrdata, r, lm;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [11:0] pins, base, chan_out, v;
  logic [13:0] fb_out, fm;
  logic [15:0] host_cmd, width, hc;
  logic [3:0] ch;
  int bad_count, n_tests;
  localparam logic [7:0] RA [0:8] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10,
                                      8'h14, 8'h20, 8'h24, 8'h3C};
  localparam logic [31:0] RV [0:8] = '{32'h0, 32'h0, 32'h0, 32'h07070707,
    32'h07070707, 32'h07070707, 32'h76543210, 32'h0000BA98, 32'h0};
  localparam logic [7:0] GI [0:3] = '{8'h01, 8'h06, 8'h07, 8'h08};
  localparam int GC [0:3] = '{100, 6, 10, 50};

  initial hclk = 1'b0;
  always #50 hclk = ~hclk;

  icfe_top #(.GP6_CYC(6), .GP7_CYC(10), .GP8_CYC(50)) u_icfe_top (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .pin_in(pins), .fb_out(fb_out), .chan_out(chan_out),
    .host_cmd(host_cmd), .logic_in(logic_in));

  icfe_field_model u_icfe_field_model (.hclk(hclk), .hresetn(hresetn),
    .base(base), .go(go), .ch(ch), .width(width), .pin_in(pins));

  // ----------------------------------------------------------------
  // Checking and reporting
  // ----------------------------------------------------------------
  task test_done;
    $display("checks %0d, mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task check(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task end_test(input string name);
    $display("test %s done", name);
  endtask

  // Expected combined logic input; host bits only count with no feedback
  function automatic logic exp_logic(input logic [11:0] c,
      input logic [31:0] m, input logic [13:0] f, input logic [13:0] b,
      input logic [15:0] h);
    return (|(c & m[11:0])) | (|(b & f)) | ((f == 14'h0) & |(h & m[27:12]));
  endfunction

  // ----------------------------------------------------------------
  // AHB-Lite master; every wait bounded
  // ----------------------------------------------------------------
  task wait_ready;
    int n;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (hreadyout !== 1'b1 && n < 20);
    if (hreadyout !== 1'b1) begin
      bad_count++;
      test_done;
    end
  endtask

  task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= {24'h000000, a};
    hwrite <= w;
    wait_ready;
    htrans <= 2'b00;
    hwdata <= w ? d : 32'h0;
    wait_ready;
    r = hrdata;
  endtask

  task wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask

  task rd(input logic [7:0] a);
    bus(1'b0, a, 32'h0);
  endtask

  // One pulse on a line, then watch the channel for any high level
  task pulse(input logic [3:0] c, input int w, input int len, input logic e);
    logic s;
    ch <= c;
    width <= w[15:0];
    go <= 1'b1;
    @(posedge hclk);
    go <= 1'b0;
    s = 1'b0;
    repeat (w + len + 20) begin
      @(posedge hclk);
      s = s | chan_out[c];
    end
    check({31'h0, s}, {31'h0, e});
  endtask

  // Hang guard, far beyond the longest sequence
  initial begin
    repeat (60000) @(posedge hclk);
    bad_count++;
    test_done;
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    {hresetn, hsel, hwrite, go} = 4'h0;
    haddr = 32'h0;
    hwdata = 32'h0;
    htrans = 2'b00;
    hsize = 3'h2;
    base = 12'h000;
    ch = 4'h0;
    width = 16'h0000;
    fb_out = 14'h0000;
    bad_count = 0;
    n_tests = 0;
    r = $urandom(4);
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    check({host_cmd, 2'h0, hresp, logic_in, chan_out}, 32'h0);
    for (int i = 0; i < 9; i++) begin
      rd(RA[i]);
      check(r, RV[i]);
    end
    end_test("reset");
    // Host command bits, random patterns
    for (int i = 0; i < 4; i++) begin
      hc = $urandom;
      wr(8'h1C, {16'h0, hc});
      repeat (2) @(posedge hclk);
      check({16'h0, host_cmd}, {16'h0, hc});
    end
    end_test("host");
    // Stopped: fixed level whatever the pins do; fast filters
    wr(8'h0C, 32'h0);
    wr(8'h10, 32'h0);
    wr(8'h14, 32'h0);
    v = $urandom;
    wr(8'h08, {20'h0, v});
    repeat (12) @(posedge hclk);
    check({20'h0, chan_out}, {20'h0, v});
    base <= 12'hFFF;
    repeat (12) @(posedge hclk);
    check({20'h0, chan_out}, {20'h0, v});
    wr(8'h00, 32'h1);
    repeat (12) @(posedge hclk);
    check({20'h0, chan_out}, 32'h00000FFF);
    end_test("stop");
    // Inversion against random pin levels
    v = $urandom;
    wr(8'h04, {20'h0, v});
    base <= $urandom;
    repeat (12) @(posedge hclk);
    check({20'h0, chan_out}, {20'h0, base ^ v});
    wr(8'h04, 32'h0);
    base <= 12'h000;
    repeat (12) @(posedge hclk);
    end_test("invert");
    // General filter: just short is dropped, just long passes
    for (int i = 0; i < 4; i++) begin
      wr(8'h0C, {24'h0, GI[i]});
      pulse(4'h0, GC[i] - 2, GC[i], 1'b0);
      pulse(4'h0, GC[i] + 4, GC[i], 1'b1);
    end
    // Index above the table clamps to the longest time
    wr(8'h0C, 32'h0000000F);
    pulse(4'h0, 46, 50, 1'b0);
    end_test("general filter");
    // Pulse filter: each mode at its clamped top speed, then the slowest speed, index 0
    for (int m = 0; m < 5; m++) begin
      wr(8'h0C, {24'h0, 1'b1, m[2:0], 4'hF});
      pulse(4'h0, 4, 4, 1'b1);
    end
    wr(8'h0C, 32'h00000080);
    pulse(4'h0, 100, 500, 1'b0);
    pulse(4'h0, 510, 500, 1'b1);
    end_test("pulse filter");
    // Serial encoder link overrides a slow filter, unlink restores default
    wr(8'h0C, 32'h00000008);
    wr(8'h18, 32'h00070001);
    pulse(4'h0, 4, 4, 1'b1);
    wr(8'h18, 32'h0);
    rd(8'h0C);
    check(r, 32'h00000007);
    pulse(4'h0, 4, 10, 1'b0);
    end_test("link");
    // One pin routed to two channels
    wr(8'h20, 32'h76543215);
    base <= 12'h020;
    repeat (30) @(posedge hclk);
    check({20'h0, chan_out & 12'h021}, 32'h00000021);
    rd(8'h30);
    check(r, 32'h00210020);
    wr(8'h20, 32'h76543210);
    end_test("select");
    // Combined logic input; first rounds without feedback
    for (int i = 0; i < 8; i++) begin
      lm = $urandom;
      fm = (i < 4) ? 14'h0 : 14'(1 << (i % 3));
      hc = $urandom;
      base <= (i % 2 == 0) ? 12'h000 : 12'($urandom);
      fb_out <= $urandom;
      wr(8'h28, lm);
      wr(8'h2C, {18'h0, fm});
      wr(8'h1C, {16'h0, hc});
      repeat (30) @(posedge hclk);
      check({31'h0, logic_in},
            {31'h0, exp_logic(base, lm, fm, fb_out, hc)});
    end
    end_test("logic");
    test_done;
  end
endmodule
